/* design/pll_clock_pkg.sv */
// Shared constants, field layouts and carrier types of the PLL clock synthesis block.
// Assumes a single 125 MHz system clock and divider fields supplied from the same domain.
package pll_clock_pkg;

  // ****************************************************************
  // Clock and field layout.
  // ****************************************************************
  localparam int             SYS_CLK_MHZ        = 125;
  localparam int             REG_W              = 16;
  localparam int             PRESCALE_LSB       = 0;
  localparam int             PRESCALE_W         = 5;
  localparam int             POSTSCALE_LSB      = 6;
  localparam int             POSTSCALE_W        = 2;
  localparam int             FEEDBACK_LSB       = 0;
  localparam int             FEEDBACK_W         = 9;
  localparam int             PRE_FAC_W          = 6;
  localparam int             M_W                = 10;
  localparam int             POST_FAC_W         = 4;
  localparam int             CREDIT_W           = 16;

  // ****************************************************************
  // Factor encodings and reset values.
  // ****************************************************************
  localparam logic [PRE_FAC_W-1:0]  PRESCALE_OFFSET = 6'h02;
  localparam logic [M_W-1:0]        FEEDBACK_OFFSET = 10'h002;
  localparam logic [POST_FAC_W-1:0] POST_FAC_DIV2   = 4'h2;
  localparam logic [POST_FAC_W-1:0] POST_FAC_DIV4   = 4'h4;
  localparam logic [POST_FAC_W-1:0] POST_FAC_DIV8   = 4'h8;
  localparam logic [PRE_FAC_W-1:0]  PRE_FAC_RESET   = 6'h02;
  localparam logic [M_W-1:0]        M_RESET         = 10'h002;
  localparam logic [POST_FAC_W-1:0] POST_FAC_RESET  = 4'h2;
  localparam logic [CREDIT_W-1:0] CREDIT_MAX    = 16'hFFFF;

  typedef enum logic {
    REF_PRIMARY = 1'b0,
    REF_FAST_RC = 1'b1
  } ref_select_e;

  typedef enum logic [1:0] {
    POST_DIV2 = 2'b00,
    POST_DIV4 = 2'b01,
    POST_RSVD = 2'b10,
    POST_DIV8 = 2'b11
  } postscale_e;

  typedef struct packed {
    logic vco_in;
    logic fosc;
    logic instr;
  } clock_ticks_s;

endpackage : pll_clock_pkg

/* design/level_sync.sv */
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level from outside the system clock domain.
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset.
  input  wire logic             clk_sys_in,
  input  wire logic             resetn_in,
  // Levels.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1_ff;
      logic stage2_ff;
      logic nxt_stage1;
      logic nxt_stage2;
      always_comb begin
        nxt_stage1 = async_in[i];
        nxt_stage2 = stage1_ff;
      end
      always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
          stage1_ff <= 1'b0;
          stage2_ff <= 1'b0;
        end else begin
          stage1_ff <= nxt_stage1;
          stage2_ff <= nxt_stage2;
        end
      end
      assign sync_out[i] = stage2_ff;
    end
  endgenerate

endmodule : level_sync

/* design/pll_clock_synthesis.sv */
// PLL clock synthesis: prescale, feedback multiply and postscale as tick enables.
// Assumes oscillator pins are asynchronous and divider fields come from the system clock domain.
// Function
// RL1: Either the primary oscillator or the fast RC oscillator may be the reference.
// RL2: Reference divided by prescale factor 2..33 from divider register bits 4..0.
// RL3: Software keeps the VCO input between 0.8 MHz and 8 MHz.
// RL4: VCO input multiplied by factor from feedback register bits 8..0.
// RL5: Software keeps the VCO output between 100 MHz and 200 MHz.
// RL6: VCO output divided by postscale 2, 4 or 8 from divider bits 7..6.
// RL7: Software keeps the output clock between 12.5 MHz and 80 MHz.
// RL8: Output rate is reference times feedback over prescale times postscale.
// RL9: Instructions run at half the output clock rate.
// RL10: Prescale 0 gives 2, feedback 0x1E gives 32, postscale 0 gives 2.
// RL11: Prescale factor is field plus two; feedback factor is field plus two.
// RL12: Postscale codes 00, 01, 11 divide by 2, 4, 8.
`timescale 1ns/1ps
module pll_clock_synthesis
  import pll_clock_pkg::*;
(
  // Clock and reset.
  input  wire logic                            clk_sys_in,
  input  wire logic                            resetn_in,
  // Oscillator pins.
  input  wire logic                            primary_osc_in,
  input  wire logic                            internal_fast_rc_oscillator_in,
  // Configuration.
  input  wire pll_clock_pkg::ref_select_e      ref_select_in,
  input  wire logic [pll_clock_pkg::REG_W-1:0] clock_divider_register_in,
  input  wire logic [pll_clock_pkg::REG_W-1:0] feedback_divisor_register_in,
  // Clock enables and decoded factors.
  output pll_clock_pkg::clock_ticks_s          ticks_out,
  output logic [pll_clock_pkg::PRE_FAC_W-1:0]  input_prescale_factor_out,
  output logic [pll_clock_pkg::M_W-1:0]        feedback_factor_out,
  output logic [pll_clock_pkg::POST_FAC_W-1:0] output_postscale_factor_out
);

  import pll_clock_pkg::*;

  // ****************************************************************
  // Pin synchronisers and edge detection.
  // ****************************************************************
  logic [1:0]          osc_sync;
  logic [1:0]          osc_last_ff;
  logic [1:0]          osc_edge;
  logic                ref_edge;

  level_sync #(.WIDTH(2)) u_osc_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   ({internal_fast_rc_oscillator_in, primary_osc_in}),
    .sync_out   (osc_sync)
  );

  // ****************************************************************
  // Divider state.
  // ****************************************************************
  logic [PRESCALE_W-1:0]  input_prescale_select;
  logic [FEEDBACK_W-1:0]  vco_feedback_multiplier;
  postscale_e             vco_output_postscale;
  logic [PRE_FAC_W-1:0]   pre_fac;
  logic [M_W-1:0]         m_fac;
  logic [POST_FAC_W-1:0]  post_fac;
  logic [PRE_FAC_W-1:0]   pre_cnt_ff;
  logic [PRE_FAC_W-1:0]   nxt_pre_cnt;
  logic [CREDIT_W-1:0]    credit_ff;
  logic [CREDIT_W-1:0]    nxt_credit;
  logic [CREDIT_W:0]      credit_sum;
  logic                   instr_phase_ff;
  logic                   nxt_instr_phase;
  logic                   vco_tick;
  logic                   fosc_tick;
  clock_ticks_s           ticks_ff;
  clock_ticks_s           nxt_ticks;
  logic [PRE_FAC_W-1:0]   pre_fac_ff;
  logic [M_W-1:0]         m_ff;
  logic [POST_FAC_W-1:0]  post_fac_ff;

  always_comb begin
    input_prescale_select   = clock_divider_register_in[PRESCALE_LSB +: PRESCALE_W];
    vco_feedback_multiplier = feedback_divisor_register_in[FEEDBACK_LSB +: FEEDBACK_W];
    vco_output_postscale    = postscale_e'(clock_divider_register_in[POSTSCALE_LSB +: POSTSCALE_W]);
    pre_fac = {1'b0, input_prescale_select} + PRESCALE_OFFSET;     // see RL11, RL10
    m_fac   = {1'b0, vco_feedback_multiplier} + FEEDBACK_OFFSET;   // see RL11, RL10
    unique case (vco_output_postscale)
      POST_DIV2: post_fac = POST_FAC_DIV2;                         // see RL12, RL10
      POST_DIV4: post_fac = POST_FAC_DIV4;                         // see RL12
      POST_RSVD: post_fac = POST_FAC_DIV4;
      POST_DIV8: post_fac = POST_FAC_DIV8;                         // see RL12
    endcase
    osc_edge = osc_sync & ~osc_last_ff;
    ref_edge = (ref_select_in == REF_FAST_RC) ? osc_edge[1] : osc_edge[0]; // see RL1
    // Prescaler: one VCO input tick per prescale factor of reference edges.
    nxt_pre_cnt = pre_cnt_ff;
    vco_tick    = 1'b0;
    if (ref_edge) begin
      if (pre_cnt_ff >= pre_fac - 6'h01) begin                    // see RL2
        nxt_pre_cnt = '0;
        vco_tick    = 1'b1;
      end else begin
        nxt_pre_cnt = pre_cnt_ff + 6'h01;
      end
    end
    // Feedback adds its factor per VCO input tick; each output tick spends the postscale.
    fosc_tick  = (credit_ff >= CREDIT_W'(post_fac));               // see RL6, RL8
    credit_sum = {1'b0, credit_ff} + (vco_tick ? (CREDIT_W+1)'(m_fac) : '0) // see RL4
               - (fosc_tick ? (CREDIT_W+1)'(post_fac) : '0);
    nxt_credit = credit_sum[CREDIT_W] ? CREDIT_MAX : credit_sum[CREDIT_W-1:0];
    nxt_instr_phase  = fosc_tick ? ~instr_phase_ff : instr_phase_ff;
    nxt_ticks.vco_in = vco_tick;
    nxt_ticks.fosc   = fosc_tick;
    nxt_ticks.instr  = fosc_tick & instr_phase_ff;                 // see RL9
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_last_ff    <= 2'h0;
      pre_cnt_ff     <= '0;
      credit_ff      <= '0;
      instr_phase_ff <= 1'b0;
      ticks_ff       <= '0;
      pre_fac_ff     <= PRE_FAC_RESET;
      m_ff           <= M_RESET;
      post_fac_ff    <= POST_FAC_RESET;
    end else begin
      osc_last_ff    <= osc_sync;
      pre_cnt_ff     <= nxt_pre_cnt;
      credit_ff      <= nxt_credit;
      instr_phase_ff <= nxt_instr_phase;
      ticks_ff       <= nxt_ticks;
      pre_fac_ff     <= pre_fac;
      m_ff           <= m_fac;
      post_fac_ff    <= post_fac;
    end
  end

  assign ticks_out                   = ticks_ff;
  assign input_prescale_factor_out   = pre_fac_ff;
  assign feedback_factor_out         = m_ff;
  assign output_postscale_factor_out = post_fac_ff;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  chk_ref_source_rc: assert property ( // see RL1
    (ref_select_in == REF_FAST_RC && !osc_edge[1]) |=> $stable(pre_cnt_ff))
    else $error("Prescaler moved without a fast RC edge.");

  chk_ref_source_pri: assert property ( // see RL1
    (ref_select_in == REF_PRIMARY && !osc_edge[0]) |=> $stable(pre_cnt_ff))
    else $error("Prescaler moved without a primary edge.");

  chk_prescale_wrap: assert property ( // see RL2
    (ref_edge && pre_cnt_ff == pre_fac - 6'h01) |=> (pre_cnt_ff == '0) && ticks_ff.vco_in)
    else $error("Prescaler did not wrap at its factor.");

  chk_prescale_zero: assert property ( // see RL10
    (input_prescale_select == '0 && pre_cnt_ff == 6'h00 && ref_edge) |=> !ticks_ff.vco_in
    ##0 (pre_cnt_ff == 6'h01))
    else $error("Prescale field zero did not divide by two.");

  chk_feedback_add: assert property ( // see RL4
    (vco_tick && !fosc_tick && credit_ff < 16'h8000)
    |=> credit_ff == $past(credit_ff) + CREDIT_W'($past(m_fac)))
    else $error("Feedback credit did not grow by the factor.");

  chk_feedback_1e: assert property ( // see RL10
    (vco_feedback_multiplier == 9'h01E) |=> (feedback_factor_out == 10'h020))
    else $error("Feedback field 0x1E did not give 32.");

  chk_post_emit: assert property ( // see RL6
    (credit_ff >= CREDIT_W'(post_fac)) |=> ticks_ff.fosc)
    else $error("Output tick missing with enough credit.");

  chk_post_decode: assert property ( // see RL12
    (vco_output_postscale == POST_DIV8) |=> (output_postscale_factor_out == 4'h8))
    else $error("Postscale code 11 did not give 8.");

  chk_fosc_ratio: assert property ( // see RL8
    (credit_ff < CREDIT_W'(post_fac)) |=> !ticks_ff.fosc)
    else $error("Output tick without enough credit.");

  chk_instr_half: assert property ( // see RL9
    (fosc_tick && !instr_phase_ff) |=> !ticks_ff.instr ##0 ticks_ff.fosc)
    else $error("Instruction tick on the wrong output phase.");

  chk_post_spend: assert property ( // see RL6
    (fosc_tick && !vco_tick) |=> credit_ff == $past(credit_ff) - CREDIT_W'($past(post_fac)))
    else $error("Output tick did not spend the postscale factor.");

  chk_instr_pair: assert property ( // see RL9
    (fosc_tick && instr_phase_ff) |=> ticks_ff.instr && ticks_ff.fosc)
    else $error("Instruction tick missing on the second output tick.");

  chk_prescale_step: assert property ( // see RL2
    (ref_edge && pre_cnt_ff < pre_fac - 6'h01)
    |=> (pre_cnt_ff == $past(pre_cnt_ff) + 6'h01) && !ticks_ff.vco_in)
    else $error("Prescaler did not count a reference edge.");

  chk_vco_quiet: assert property ( // see RL2
    !ref_edge |=> !ticks_ff.vco_in)
    else $error("VCO input tick without a reference edge.");

  chk_prescale_decode: assert property ( // see RL11
    1'b1 |=> input_prescale_factor_out == $past(input_prescale_select) + PRESCALE_OFFSET)
    else $error("Prescale factor is not the field plus two.");

  chk_feedback_decode: assert property ( // see RL11
    1'b1 |=> feedback_factor_out == $past(vco_feedback_multiplier) + FEEDBACK_OFFSET)
    else $error("Feedback factor is not the field plus two.");

  // ****************************************************************
  // Covers.
  // ****************************************************************
  cov_vco_tick: cover property (ticks_ff.vco_in);
  cov_fosc_tick: cover property (ticks_ff.fosc ##1 ticks_ff.fosc);
  cov_instr_tick: cover property (ticks_ff.instr);
  cov_rc_div8: cover property (ref_select_in == REF_FAST_RC && post_fac == POST_FAC_DIV8
    && fosc_tick);
  cov_post_rsvd: cover property (vco_output_postscale == POST_RSVD && fosc_tick);

endmodule : pll_clock_synthesis

/* test/osc_source.sv */
// Behavioural model of the two reference oscillators feeding the PLL block.
// Assumes a stopped oscillator parks low and restarts at its own free phase.
`timescale 1ns/1ps
module osc_source #(
  parameter realtime HALF_PRIMARY = 64.0,
  parameter realtime HALF_RC      = 37.0
) (
  // Run controls.
  input  wire logic run_primary_in,
  input  wire logic run_rc_in,
  // Oscillator pins and rising edge counts.
  output logic      primary_osc_out,
  output logic      fast_rc_out,
  output int        primary_edges_out,
  output int        rc_edges_out
);
  // Either source can serve as the reference.
  initial begin
    primary_osc_out   = 1'b0;
    primary_edges_out = 0;
    forever begin
      #(HALF_PRIMARY);
      if (run_primary_in || primary_osc_out) begin
        primary_osc_out = ~primary_osc_out;
        if (primary_osc_out) primary_edges_out++;
      end
    end
  end
  initial begin
    fast_rc_out  = 1'b0;
    rc_edges_out = 0;
    forever begin
      #(HALF_RC);
      if (run_rc_in || fast_rc_out) begin
        fast_rc_out = ~fast_rc_out;
        if (fast_rc_out) rc_edges_out++;
      end
    end
  end
endmodule : osc_source

/* test/tb.sv */
// Self-checking bench for the PLL clock synthesis block with random divider settings.
// Assumes the oscillator model drives the pins and configuration is held across each window.
`timescale 1ns/1ps
module tb;
  import pll_clock_pkg::*;
  localparam real HALF_P = 64.0;
  localparam real HALF_R = 37.0;
  logic clk_sys_in = 1'b0;
  logic resetn_in  = 1'b0;
  ref_select_e sel = REF_PRIMARY;
  logic [15:0] cdiv = 16'h0000;
  logic [15:0] fbd  = 16'h0000;
  logic p_osc, rc_osc;
  int   p_edges, rc_edges;
  clock_ticks_s ticks;
  logic [PRE_FAC_W-1:0]  pre_o;
  logic [M_W-1:0]        m_o;
  logic [POST_FAC_W-1:0] post_o;
  int errors = 0, checks_done = 0;
  int n_vco, n_fosc, n_ins;
  logic win = 1'b0;
  // ****************************************************************
  // Clock, partner and design.
  // ****************************************************************
  always #4 clk_sys_in = ~clk_sys_in;
  osc_source #(.HALF_PRIMARY(HALF_P), .HALF_RC(HALF_R)) u_osc (.run_primary_in(1'b1),
    .run_rc_in(1'b1), .primary_osc_out(p_osc),
    .fast_rc_out(rc_osc), .primary_edges_out(p_edges), .rc_edges_out(rc_edges));
  pll_clock_synthesis DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .primary_osc_in(p_osc), .internal_fast_rc_oscillator_in(rc_osc), .ref_select_in(sel),
    .clock_divider_register_in(cdiv), .feedback_divisor_register_in(fbd), .ticks_out(ticks),
    .input_prescale_factor_out(pre_o), .feedback_factor_out(m_o),
    .output_postscale_factor_out(post_o));
  always @(posedge clk_sys_in) if (win) begin
    n_vco  <= n_vco + int'(ticks.vco_in);
    n_fosc <= n_fosc + int'(ticks.fosc);
    n_ins  <= n_ins + int'(ticks.instr);
  end
  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic int post_div(input logic [1:0] c);
    return (c == 2'b00) ? 2 : (c == 2'b11) ? 8 : 4;
  endfunction : post_div
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  function automatic bit near(input int got, input int exp, input int tol);
    return (got >= exp - tol) && (got <= exp + tol);
  endfunction : near
  task automatic final_report();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Applies one setting, checks the decoded factors and the tick rates over a window.
  task automatic run_cfg(input ref_select_e s, input logic [4:0] pre, input logic [1:0] post,
                         input logic [8:0] fb);
    int npre, m, npost, e0, e, tol;
    npre  = int'(pre) + 2;
    m     = int'(fb) + 2;
    npost = post_div(post);
    @(negedge clk_sys_in);
    sel  = s;
    cdiv = {8'($urandom_range(0, 255)), post, 1'($urandom_range(0, 1)), pre};
    fbd  = {7'($urandom_range(0, 127)), fb};
    repeat (300) @(negedge clk_sys_in);
    chk(pre_o === 6'(npre), "prescale factor");
    chk(m_o === 10'(m), "feedback factor");
    chk(post_o === 4'(npost), "postscale factor");
    n_vco = 0;
    n_fosc = 0;
    n_ins = 0;
    e0  = (s == REF_PRIMARY) ? p_edges : rc_edges;
    win = 1'b1;
    repeat (4000) @(negedge clk_sys_in);
    win = 1'b0;
    e   = ((s == REF_PRIMARY) ? p_edges : rc_edges) - e0;
    tol = 2 * m / npost + 2;
    chk(near(n_vco, e / npre, 1), "vco tick count");
    chk(near(n_fosc, e * m / (npre * npost), tol), "output tick count");
    chk(near(n_ins, e * m / (npre * npost * 2), tol / 2 + 1), "instr tick count");
  endtask : run_cfg
  // ****************************************************************
  // Scenarios and watchdog.
  // ****************************************************************
  initial begin
    int pre, post, mlo, mhi;
    real vin, vlo, vhi;
    ref_select_e s;
    logic [1:0] codes [3] = '{2'b00, 2'b01, 2'b11};
    void'($urandom(32'hC2BA5B8D));
    repeat (6) @(negedge clk_sys_in);
    chk(pre_o === PRE_FAC_RESET && m_o === M_RESET && post_o === POST_FAC_RESET, "reset factors");
    resetn_in = 1'b1;
    run_cfg(REF_PRIMARY, 5'h00, 2'b00, 9'h01E);
    run_cfg(REF_FAST_RC, 5'h01, 2'b00, 9'h01E);
    run_cfg(REF_PRIMARY, 5'h1F, 2'b11, 9'h1FF);
    run_cfg(REF_FAST_RC, 5'h02, 2'b10, 9'h030);
    for (int i = 0; i < 8; i++) begin
      s    = ref_select_e'($urandom_range(0, 1));
      pre  = $urandom_range(0, 7);
      post = $urandom_range(0, 2);
      vin  = ((s == REF_PRIMARY) ? 500.0 / HALF_P : 500.0 / HALF_R) / (pre + 2);
      vlo  = (12.5 * post_div(codes[post]) > 100.0) ? 12.5 * post_div(codes[post]) : 100.0;
      vhi  = (80.0 * post_div(codes[post]) < 200.0) ? 80.0 * post_div(codes[post]) : 200.0;
      mlo  = int'($ceil(vlo / vin));
      mhi  = int'($floor(vhi / vin));
      run_cfg(s, 5'(pre), codes[post], 9'($urandom_range(mlo - 2, mhi - 2)));
    end
    resetn_in = 1'b0;
    @(negedge clk_sys_in);
    chk(ticks === 3'b000 && pre_o === PRE_FAC_RESET && post_o === POST_FAC_RESET, "mid-run reset");
    final_report();
  end
  initial begin
    #(60000 * 8);
    errors++;
    final_report();
  end
endmodule : tb
